/* src/ema_pkg.sv */
// shared constants and types for the energy metering accumulator
package ema_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ASCALE  = 8'h04;
  localparam logic [7:0] OFF_RSCALE  = 8'h08;
  localparam logic [7:0] OFF_TIME    = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_LIVE0   = 8'h20;
  localparam logic [7:0] OFF_RPT0    = 8'h30;
  localparam logic [7:0] OFF_BANK_M  = 8'hF0;
  localparam logic [7:0] OFF_WORD_M  = 8'h0C;

  // control register field positions
  localparam int PER_LSB  = 0;
  localparam int PER_W    = 3;
  localparam int SRC_BIT  = 4;
  localparam int CUM_BIT  = 5;
  localparam int DIR_BIT  = 6;
  localparam int VDEF_BIT = 7;
  localparam int CTRL_W   = 8;

  // time register field positions
  localparam int TMIN_LSB = 0;
  localparam int TSEC_LSB = 8;

  // accumulation period codes
  typedef enum logic [2:0] {
    PER_OFF = 3'h0,
    PER_5   = 3'h1,
    PER_10  = 3'h2,
    PER_15  = 3'h3,
    PER_30  = 3'h4,
    PER_60  = 3'h5
  } ema_period_t;

  // input source and reference direction encodings
  localparam logic SRC_MEAS  = 1'b0;
  localparam logic SRC_PULSE = 1'b1;
  localparam logic DIR_DEM   = 1'b0;
  localparam logic DIR_SUP   = 1'b1;

  // control reset value: 30 min, measurement, no cumulation, demand
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h04;

  // pulse weight range, in kilo-units per pulse
  localparam int SCALE_W = 14;
  localparam logic [SCALE_W-1:0] SCALE_MIN = 14'h0001;
  localparam logic [SCALE_W-1:0] SCALE_MAX = 14'h2710;
  localparam logic [SCALE_W-1:0] SCALE_RST = 14'h0064;
  localparam logic [9:0] KILO = 10'h3E8;

  // accumulator channels
  localparam int NCH     = 4;
  localparam int CH_AD   = 0;
  localparam int CH_AS   = 1;
  localparam int CH_RD   = 2;
  localparam int CH_RS   = 3;
  localparam int ACC_W   = 32;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SECOND_NS     = 1000000000;
  localparam int CYC_PER_SEC   = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [5:0] LAST_SEC = 6'h3B;
  localparam logic [5:0] LAST_MIN = 6'h3B;

  // sequencer states
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ARM = 2'b01,
    ST_RUN = 2'b10
  } ema_state_t;

endpackage

/* src/ema_pulse_edge.sv */
// synchronises meter pulse pins and flags their rising edges
module ema_pulse_edge #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and gating
  input  wire logic [N-1:0] pin_in,
  input  wire logic         enable,
  // one-cycle edge flags
  output logic      [N-1:0] rise
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // two-stage sync then a history stage for the edge
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          rise[g] <= 1'b0;
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          rise[g] <= enable & s2_q & ~s3_q;
        end
      end
    end
  endgenerate

endmodule

/* src/ema_volt_sel.sv */
// chooses one of two three-phase voltage sets for the protection consumers
module ema_volt_sel #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // voltage sources
  input  wire logic [3*W-1:0] volt_a,
  input  wire logic [3*W-1:0] volt_b,
  // selection
  input  wire logic           default_is_b,
  input  wire logic           choose,
  // routed voltages
  output logic      [3*W-1:0] volt_out
);

  // low choose takes the default module, high takes the other
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_out <= '0;
    end else if (choose ^ default_is_b) begin
      volt_out <= volt_b;
    end else begin
      volt_out <= volt_a;
    end
  end

endmodule

/* src/ema_top.sv */
// energy metering accumulator with apb registers and voltage source selection
module ema_top
  import ema_pkg::*;
#(
  parameter int PW      = 24,
  parameter int VW      = 16,
  parameter int SEC_CYC = CYC_PER_SEC
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // internal power samples, energy per sample in unit-hours
  input  wire logic signed [PW-1:0] meas_p,
  input  wire logic signed [PW-1:0] meas_q,
  input  wire logic              meas_valid,
  // external meter pulse pins
  input  wire logic              active_demand_pulse_in,
  input  wire logic              active_supply_pulse_in,
  input  wire logic              reactive_demand_pulse_in,
  input  wire logic              reactive_supply_pulse_in,
  // accumulator clear from logic, acted on in cumulative mode only
  input  wire logic              accum_clear_in,
  // report events
  output logic                   report_valid,
  output logic      [ACC_W-1:0]  report_active_demand,
  output logic      [ACC_W-1:0]  report_active_supply,
  output logic      [ACC_W-1:0]  report_reactive_demand,
  output logic      [ACC_W-1:0]  report_reactive_supply,
  // voltage selection
  input  wire logic [3*VW-1:0]   volt_src_a,
  input  wire logic [3*VW-1:0]   volt_src_b,
  input  wire logic              bus_voltage_choose_in,
  output logic      [3*VW-1:0]   volt_protect
);

  // settings
  logic [CTRL_W-1:0]  ctrl_q;
  logic [SCALE_W-1:0] ascale_q;
  logic [SCALE_W-1:0] rscale_q;
  ema_period_t        period_select;
  logic               src_pulse;
  logic               cumul;
  logic               ref_supply;

  // apb handshake and decode
  logic               acc_ph;
  logic               wr_fire;
  logic [7:0]         wdword;
  logic               mapped;
  logic [31:0]        rd_d;

  // real-time clock
  logic [31:0]        div_q;
  logic               sec_tick;
  logic [5:0]         sec_q;
  logic [5:0]         min_q;
  logic               time_wr;

  // sequencing
  ema_state_t         state_q;
  logic               setting_chg;
  logic               boundary;
  logic               accum_on;
  logic               rpt_fire;
  logic [NCH-1:0]     pulse_rise;
  logic [ACC_W-1:0]   acc_q [NCH];
  logic [ACC_W-1:0]   rpt_q [NCH];
  logic [ACC_W-1:0]   inc   [NCH];
  logic [PW-1:0]      p_mag;
  logic [PW-1:0]      q_mag;
  logic [ACC_W-1:0]   a_pulse_e;
  logic [ACC_W-1:0]   r_pulse_e;

  assign period_select = ema_period_t'(ctrl_q[PER_LSB +: PER_W]);
  assign src_pulse     = ctrl_q[SRC_BIT];
  assign cumul         = ctrl_q[CUM_BIT];
  assign ref_supply    = ctrl_q[DIR_BIT];

  // boundary test: minute is a whole multiple of the period
  function automatic logic on_grid(input ema_period_t per, input logic [5:0] m);
    logic r;
    r = 1'b0;
    case (per)
      PER_5:   r = (m % 6'd5)  == 6'd0;
      PER_10:  r = (m % 6'd10) == 6'd0;
      PER_15:  r = (m % 6'd15) == 6'd0;
      PER_30:  r = (m % 6'd30) == 6'd0;
      PER_60:  r = m == 6'd0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // apb: one wait state, answer on the second access cycle
  assign acc_ph  = psel & penable;
  assign wr_fire = acc_ph & pready & pwrite;
  assign wdword  = paddr & OFF_WORD_M;
  assign mapped  = (paddr[1:0] == 2'b00) &&
                   (paddr <= OFF_STATUS ||
                    (paddr & OFF_BANK_M) == OFF_LIVE0 ||
                    (paddr & OFF_BANK_M) == OFF_RPT0);

  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    if ((paddr & OFF_BANK_M) == OFF_LIVE0) begin
      rd_d = acc_q[wdword[3:2]];
    end else if ((paddr & OFF_BANK_M) == OFF_RPT0) begin
      rd_d = rpt_q[wdword[3:2]];
    end else begin
      case (paddr)
        OFF_CTRL:   rd_d[CTRL_W-1:0]  = ctrl_q;
        OFF_ASCALE: rd_d[SCALE_W-1:0] = ascale_q;
        OFF_RSCALE: rd_d[SCALE_W-1:0] = rscale_q;
        OFF_TIME:   rd_d = {18'h0, sec_q, 2'b00, min_q};
        OFF_STATUS: rd_d = {30'h0, state_q};
        default:    rd_d = 32'h0000_0000;
      endcase
    end
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_ph & ~pready;
      pslverr <= acc_ph & ~pready & ~mapped;
      if (acc_ph & ~pready & ~pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // settings registers; writes of a new in-range value count as a change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= CTRL_RST;
      ascale_q    <= SCALE_RST;
      rscale_q    <= SCALE_RST;
      setting_chg <= 1'b0;
    end else begin
      setting_chg <= 1'b0;
      if (wr_fire && paddr == OFF_CTRL && pwdata[CTRL_W-1:0] != ctrl_q) begin
        ctrl_q      <= pwdata[CTRL_W-1:0];
        setting_chg <= 1'b1;
      end
      if (wr_fire && paddr == OFF_ASCALE && pwdata[SCALE_W-1:0] != ascale_q &&
          pwdata[31:SCALE_W] == '0 && pwdata[SCALE_W-1:0] >= SCALE_MIN &&
          pwdata[SCALE_W-1:0] <= SCALE_MAX) begin
        ascale_q    <= pwdata[SCALE_W-1:0];
        setting_chg <= 1'b1;
      end
      if (wr_fire && paddr == OFF_RSCALE && pwdata[SCALE_W-1:0] != rscale_q &&
          pwdata[31:SCALE_W] == '0 && pwdata[SCALE_W-1:0] >= SCALE_MIN &&
          pwdata[SCALE_W-1:0] <= SCALE_MAX) begin
        rscale_q    <= pwdata[SCALE_W-1:0];
        setting_chg <= 1'b1;
      end
    end
  end

  // one-second enable from the system clock
  assign sec_tick = div_q == 32'(SEC_CYC - 1);
  assign time_wr  = wr_fire && paddr == OFF_TIME;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 32'h0000_0000;
    end else if (sec_tick || time_wr) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  // minute and second of the hour; a write sets them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
    end else if (time_wr) begin
      sec_q <= (pwdata[TSEC_LSB +: 6] > LAST_SEC) ? 6'h00 : pwdata[TSEC_LSB +: 6];
      min_q <= (pwdata[TMIN_LSB +: 6] > LAST_MIN) ? 6'h00 : pwdata[TMIN_LSB +: 6];
    end else if (sec_tick) begin
      if (sec_q == LAST_SEC) begin
        sec_q <= 6'h00;
        min_q <= (min_q == LAST_MIN) ? 6'h00 : min_q + 6'h01;
      end else begin
        sec_q <= sec_q + 6'h01;
      end
    end
  end

  // boundary at the tick that lands on a grid minute, second zero
  assign boundary = sec_tick && sec_q == LAST_SEC &&
                    on_grid(period_select, (min_q == LAST_MIN) ? 6'h00 : min_q + 6'h01);

  // period sequencer: arm after reset or change, run from next boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_ARM;
    end else if (setting_chg || time_wr || period_select == PER_OFF) begin
      state_q <= (period_select == PER_OFF) ? ST_OFF : ST_ARM;
    end else begin
      case (state_q)
        ST_OFF:  state_q <= ST_ARM;
        ST_ARM:  state_q <= boundary ? ST_RUN : ST_ARM;
        ST_RUN:  state_q <= ST_RUN;
        default: state_q <= ST_ARM;
      endcase
    end
  end

  assign accum_on = state_q == ST_RUN && !setting_chg && !time_wr;
  assign rpt_fire = accum_on && boundary;

  // meter pulse pins, edge flags gated to pulse mode only
  ema_pulse_edge #(
    .N (NCH)
  ) u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({reactive_supply_pulse_in, reactive_demand_pulse_in,
               active_supply_pulse_in, active_demand_pulse_in}),
    .enable  (src_pulse),
    .rise    (pulse_rise)
  );

  // pulse weights scaled from kilo-units to units
  // widen both factors first so the product is not cut to the scale width
  assign a_pulse_e = ACC_W'(ascale_q) * ACC_W'(KILO);
  assign r_pulse_e = ACC_W'(rscale_q) * ACC_W'(KILO);

  // magnitudes of the signed power samples
  assign p_mag = meas_p[PW-1] ? PW'(-meas_p) : PW'(meas_p);
  assign q_mag = meas_q[PW-1] ? PW'(-meas_q) : PW'(meas_q);

  // per-channel increment; in-phase sign goes to the reference side
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      inc[c] = '0;
    end
    if (src_pulse == SRC_PULSE) begin
      inc[CH_AD] = pulse_rise[CH_AD] ? a_pulse_e : '0;
      inc[CH_AS] = pulse_rise[CH_AS] ? a_pulse_e : '0;
      inc[CH_RD] = pulse_rise[CH_RD] ? r_pulse_e : '0;
      inc[CH_RS] = pulse_rise[CH_RS] ? r_pulse_e : '0;
    end else if (meas_valid) begin
      if (meas_p != '0) begin
        if (meas_p[PW-1] ^ (ref_supply == DIR_SUP)) begin
          inc[CH_AS] = ACC_W'(p_mag);
        end else begin
          inc[CH_AD] = ACC_W'(p_mag);
        end
      end
      if (meas_q != '0) begin
        if (meas_q[PW-1] ^ (ref_supply == DIR_SUP)) begin
          inc[CH_RS] = ACC_W'(q_mag);
        end else begin
          inc[CH_RD] = ACC_W'(q_mag);
        end
      end
    end
  end

  // four separate accumulators and their published copies
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_acc
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_q[g] <= '0;
        end else if (setting_chg || time_wr || !accum_on) begin
          acc_q[g] <= '0;
        end else if (cumul && accum_clear_in) begin
          acc_q[g] <= inc[g];
        end else if (rpt_fire && !cumul) begin
          acc_q[g] <= inc[g];
        end else begin
          acc_q[g] <= acc_q[g] + inc[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rpt_q[g] <= '0;
        end else if (rpt_fire) begin
          rpt_q[g] <= acc_q[g];
        end
      end
    end
  endgenerate

  // report event pulse and its data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_valid           <= 1'b0;
      report_active_demand   <= '0;
      report_active_supply   <= '0;
      report_reactive_demand <= '0;
      report_reactive_supply <= '0;
    end else begin
      report_valid <= rpt_fire;
      if (rpt_fire) begin
        report_active_demand   <= acc_q[CH_AD];
        report_active_supply   <= acc_q[CH_AS];
        report_reactive_demand <= acc_q[CH_RD];
        report_reactive_supply <= acc_q[CH_RS];
      end
    end
  end

  // voltage source selection for protection consumers
  ema_volt_sel #(
    .W (VW)
  ) u_vsel (
    .pclk         (pclk),
    .presetn      (presetn),
    .volt_a       (volt_src_a),
    .volt_b       (volt_src_b),
    .default_is_b (ctrl_q[VDEF_BIT]),
    .choose       (bus_voltage_choose_in),
    .volt_out     (volt_protect)
  );

endmodule

/* verif/ema_checker.sv */
// port assertions for the metering accumulator
module ema_checker
  import ema_pkg::*;
#(
  parameter int VW = 16
) (
  // clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  // reports
  input wire logic             report_valid,
  input wire logic [ACC_W-1:0] report_active_demand,
  input wire logic [ACC_W-1:0] report_reactive_supply,
  // voltages
  input wire logic [3*VW-1:0]  volt_src_a,
  input wire logic [3*VW-1:0]  volt_src_b,
  input wire logic             bus_voltage_choose_in,
  input wire logic [3*VW-1:0]  volt_protect
);
  logic [2:0]      per_q;
  logic            vdef_q;
  logic [3*VW-1:0] vsel;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow of the period and default source fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q  <= CTRL_RST[PER_LSB +: PER_W];
      vdef_q <= CTRL_RST[VDEF_BIT];
    end else if (psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
      per_q  <= pwdata[PER_LSB +: PER_W];
      vdef_q <= pwdata[VDEF_BIT];
    end
  end

  // source the routed voltage should come from
  assign vsel = (bus_voltage_choose_in ^ vdef_q) ? volt_src_b : volt_src_a;

  sequence s_req;
    psel && $rose(penable);
  endsequence
  sequence s_ans;
    pready ##1 !pready;
  endsequence

  chk_apb_answer: assert property (s_req |=> s_ans)
    else $error("apb answer not after one wait cycle");
  chk_apb_misalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  chk_ctrl_ok: assert property (pready && paddr == OFF_CTRL |-> !pslverr)
    else $error("control access refused");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_rpt_hold: assert property (!report_valid |-> $stable(report_active_demand) && $stable(report_reactive_supply))
    else $error("report data moved without report");
  chk_rpt_single: assert property (report_valid |=> !report_valid)
    else $error("report pulse too long");
  chk_rpt_off: assert property (per_q == 3'h0 && $past(per_q) == 3'h0 |-> !report_valid)
    else $error("report while period off");
  chk_volt_route: assert property ($past(presetn) |-> volt_protect == $past(vsel))
    else $error("wrong voltage source routed");
endmodule

bind ema_top ema_checker #(.VW(VW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .report_valid(report_valid), .report_active_demand(report_active_demand),
  .report_reactive_supply(report_reactive_supply), .volt_src_a(volt_src_a), .volt_src_b(volt_src_b),
  .bus_voltage_choose_in(bus_voltage_choose_in), .volt_protect(volt_protect));

/* verif/ema_meter_model.sv */
// external meter: one pulse per request, idle low
module ema_meter_model #(
  parameter int HOLD = 3
) (
  // clock and requests
  input wire logic       pclk,
  input wire logic [3:0] fire,
  // pulse pins
  output logic     [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt = 0;
  logic       on_q = 1'b0;
  logic [3:0] sel_q = 4'h0;

  assign pins = on_q ? sel_q : 4'h0;

  // high for HOLD cycles, then low at least HOLD+1 cycles so every edge counts
  always @(posedge pclk) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
      on_q <= (cnt > HOLD + 1);
    end else if (fire != 4'h0) begin
      sel_q <= fire;
      on_q <= 1'b1;
      cnt <= 2 * HOLD;
    end
  end
endmodule

/* verif/ema_top_test.sv */
// self-checking bench for the metering accumulator
module ema_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ema_pkg::*;
  localparam int SEC = 4;
  logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic               mv = 1'b0, clr = 1'b0, ch = 1'b0, pready, pslverr, rv;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, lfsr = 32'h200FFF2B, prdata, ad, as, rd, rs;
  logic signed [23:0] mp = 24'sh0, mq = 24'sh0;
  logic [3:0]         fire = 4'h0, pins;
  logic [47:0]        va = 48'h0, vb = 48'h0, vp;
  logic [32:0]        rd_q[$];
  logic [127:0]       rpt_q[$];
  int                 miscompares = 0, cmp_count = 0, cyc = 0;

  ema_top #(.SEC_CYC(SEC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .meas_p(mp), .meas_q(mq), .meas_valid(mv), .active_demand_pulse_in(pins[0]),
    .active_supply_pulse_in(pins[1]), .reactive_demand_pulse_in(pins[2]),
    .reactive_supply_pulse_in(pins[3]), .accum_clear_in(clr), .report_valid(rv),
    .report_active_demand(ad), .report_active_supply(as), .report_reactive_demand(rd),
    .report_reactive_supply(rs), .volt_src_a(va), .volt_src_b(vb), .bus_voltage_choose_in(ch),
    .volt_protect(vp));
  ema_meter_model #(.HOLD(3)) meter (.pclk(pclk), .fire(fire), .pins(pins));

  // clock
  always #10 pclk = ~pclk;

  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [127:0] e, input logic [127:0] g);
    cmp_count++;
    if (e !== g) begin
      miscompares++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // compare read answers and reports against the oldest note
  always @(posedge pclk) begin
    if (pready && !pwrite)
      chk(rd_q.size() ? 128'(rd_q.pop_front()) : 128'hX, 128'({pslverr, prdata}));
    if (rv)
      chk(rpt_q.size() ? rpt_q.pop_front() : 128'hX, {ad, as, rd, rs});
  end

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until pready; only the cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    rd_q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic sample(input logic signed [23:0] p, input logic signed [23:0] q);
    mp <= p;
    mq <= q;
    mv <= 1'b1;
    @(posedge pclk);
    mv <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input logic [3:0] f);
    fire <= f;
    @(posedge pclk);
    fire <= 4'h0;
    idle(8);
  endtask

  task automatic hold_clear();
    clr <= 1'b1;
    idle(2);
    clr <= 1'b0;
    @(posedge pclk);
  endtask

  // settings, then clock at minute 4 second 59 so minute 5 is a boundary for a 5-minute period
  task automatic arm(input logic [31:0] c);
    wr(OFF_CTRL, c);
    wr(OFF_TIME, 32'h3B04);
    idle(SEC + 6);
  endtask

  task automatic wait_rpt();
    int n;
    n = 0;
    while (rpt_q.size() && n < 1400) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // main sequence
  initial begin
    idle(2);
    presetn <= 1'b1;
    rdx(OFF_CTRL, 32'h4);
    rdx(OFF_ASCALE, 32'h64);
    rdx(OFF_RSCALE, 32'h64);
    rdx(8'h14, 32'h0, 1'b1);
    rdx(8'h02, 32'h0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL, 32'(i));
      rdx(OFF_CTRL, 32'(i));
    end
    wr(OFF_ASCALE, 32'h0);
    wr(OFF_ASCALE, 32'h2711);
    rdx(OFF_ASCALE, 32'h64);
    wr(OFF_ASCALE, 32'h2710);
    wr(OFF_RSCALE, 32'h1);
    rdx(OFF_ASCALE, 32'h2710);
    arm(32'h13);
    rdx(OFF_STATUS, 32'h1);
    arm(32'h11);
    rdx(OFF_STATUS, 32'h2);
    repeat (3) pulse(4'h1);
    pulse(4'h8);
    sample(24'sh5, 24'sh5);
    hold_clear();
    rpt_q.push_back({32'h01C9C380, 32'h0, 32'h0, 32'h3E8});
    wait_rpt();
    rpt_q.push_back(128'h0);
    wait_rpt();
    arm(32'h21);
    sample(24'sh5, -24'sh7);
    sample(24'sh5, -24'sh7);
    sample(-24'sh3, 24'sh0);
    pulse(4'hF);
    rpt_q.push_back({32'hA, 32'h3, 32'h0, 32'hE});
    wait_rpt();
    sample(24'sh1, 24'sh0);
    rpt_q.push_back({32'hB, 32'h3, 32'h0, 32'hE});
    wait_rpt();
    hold_clear();
    sample(24'sh2, 24'sh0);
    rpt_q.push_back({32'h2, 32'h0, 32'h0, 32'h0});
    wait_rpt();
    sample(24'sh3, 24'sh0);
    wr(OFF_RSCALE, 32'h5);
    rdx(OFF_LIVE0, 32'h0);
    rdx(OFF_STATUS, 32'h1);
    arm(32'h61);
    sample(24'sh5, 24'sh2);
    rpt_q.push_back({32'h0, 32'h5, 32'h0, 32'h2});
    wait_rpt();
    wr(OFF_CTRL, 32'h10);
    pulse(4'h1);
    rdx(OFF_LIVE0, 32'h0);
    rdx(OFF_STATUS, 32'h0);
    for (int i = 0; i < 16; i++) begin
      if (i == 8)
        wr(OFF_CTRL, 32'h90);
      lfsr = nx(lfsr);
      va <= {lfsr, lfsr[15:0]};
      lfsr = nx(lfsr);
      vb <= {lfsr[15:0], lfsr};
      ch <= lfsr[3];
      idle(3);
      chk(128'((ch ^ (i >= 8)) ? vb : va), 128'(vp));
    end
    if (rd_q.size() || rpt_q.size())
      miscompares++;
    print_verdict();
  end
endmodule
